// ### rtl/taxse_pkg.sv
// constants, types and register map shared by the execution core and its holding bank
package taxse_pkg;

    // data path widths
    localparam int PTR_W      = 21;
    localparam int BYTE_W     = 8;
    localparam int OPC_W      = 16;
    localparam int BANK_W     = 4;
    localparam int FADDR_W    = 12;
    localparam int WORD_AW    = 20;
    localparam int WB_ADR_W   = 8;
    localparam int WB_DAT_W   = 32;
    localparam int WB_SEL_W   = 4;
    localparam int HOLD_DEPTH = 8;

    // opcode match masks and patterns
    localparam logic [15:0] TBL_MASK   = 16'hfffc;
    localparam logic [15:0] TRD_PAT    = 16'h0008;
    localparam logic [15:0] TWR_PAT    = 16'h000c;
    localparam logic [15:0] TST_MASK   = 16'hfe00;
    localparam logic [15:0] TST_PAT    = 16'h6600;
    localparam logic [15:0] XORL_MASK  = 16'hff00;
    localparam logic [15:0] XORL_PAT   = 16'h0a00;
    localparam logic [15:0] XORF_MASK  = 16'hfc00;
    localparam logic [15:0] XORF_PAT   = 16'h1800;

    // opcode field positions
    localparam int DEST_BIT   = 9;
    localparam int ACC_BIT    = 8;

    // pointer update selections
    localparam logic [1:0] MODE_KEEP    = 2'h0;
    localparam logic [1:0] MODE_POSTINC = 2'h1;
    localparam logic [1:0] MODE_POSTDEC = 2'h2;
    localparam logic [1:0] MODE_PREINC  = 2'h3;
    localparam logic [20:0] PTR_STEP    = 21'h0_0001;

    // access bank split and banks
    localparam logic [7:0] ACC_SPLIT     = 8'h80;
    localparam logic [3:0] ACC_LOW_BANK  = 4'h0;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;

    // phases of one instruction cycle
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    // register byte offsets
    localparam logic [7:0] REG_INSTR  = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_WORK   = 8'h08;
    localparam logic [7:0] REG_TPTR   = 8'h0c;
    localparam logic [7:0] REG_TLAT   = 8'h10;
    localparam logic [7:0] REG_BANK   = 8'h14;
    localparam logic [7:0] REG_HOLD   = 8'h20;

    // status register fields
    localparam int ST_BUSY    = 0;
    localparam int ST_NEG     = 1;
    localparam int ST_ZERO    = 2;
    localparam int ST_SKIP    = 3;
    localparam int ST_ILLEGAL = 4;
    localparam int ST_CYC_LSB = 8;

    // reset values
    localparam logic [7:0]  HOLD_RESET = 8'hff;
    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [20:0] PTR_RESET  = 21'h0_0000;
    localparam logic [15:0] OPC_RESET  = 16'h0000;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

    typedef enum logic [1:0] {st_idle, st_cyc1, st_cyc2, st_cyc3} taxse_state_t;
    typedef enum logic [2:0] {op_none, op_trd, op_twr, op_tst, op_xorl, op_xorf} taxse_op_t;

endpackage

// ### rtl/taxse_hold_bank.sv
// bank of program-memory write holding registers with one write and one read port
`timescale 1ns/10ps
module taxse_hold_bank #(
    parameter int DEPTH = taxse_pkg::HOLD_DEPTH,
    parameter int IDX_W = $clog2(DEPTH)
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        we_i,
    input  wire logic [IDX_W-1:0]            wr_idx_i,
    input  wire logic [taxse_pkg::BYTE_W-1:0] wr_data_i,
    input  wire logic [IDX_W-1:0]            rd_idx_i,
    output logic      [taxse_pkg::BYTE_W-1:0] rd_data_o
);
    import taxse_pkg::*;

    logic [BYTE_W-1:0] hold [DEPTH];

    // staging bytes, erased value after reset; nothing here reaches program memory
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                hold[i] <= HOLD_RESET;
            end
        end else if (we_i) begin
            hold[wr_idx_i] <= wr_data_i; // [RL6]
        end
    end

    // read port for software inspection
    assign rd_data_o = hold[rd_idx_i];

endmodule

// ### rtl/taxse_core.sv
// execution core for table access, test-skip and exclusive-or instructions
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
// Summary of operation
// [RL1] table read opcode 10nn, four pointer modes
// [RL2] table pointer is 21-bit byte address
// [RL3] pointer bit zero picks low/high byte
// [RL4] table read fills latch, two cycles, no flags
// [RL5] table write opcode 11nn, pre-increment first
// [RL6] table write stores latch into holding register
// [RL7] table write takes two cycles, no flags
// [RL8] holding registers only stage, never program
// [RL9] test-skip opcode; zero discards next instruction
// [RL10] test-skip one, two or three cycles
// [RL11] access bit zero forces the access bank
// [RL12] xor literal into working register, flags
// [RL13] xor file register, updates negative/zero flags
// [RL14] destination bit picks working or file
// [RL15] pointer steps wrap silently at 21 bits
module taxse_core #(
    parameter int HOLD_N = taxse_pkg::HOLD_DEPTH
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [taxse_pkg::WB_ADR_W-1:0] wb_adr_i,
    input  wire logic [taxse_pkg::WB_SEL_W-1:0] wb_sel_i,
    input  wire logic [taxse_pkg::WB_DAT_W-1:0] wb_dat_i,
    output logic      [taxse_pkg::WB_DAT_W-1:0] wb_dat_o,
    output logic                                wb_ack_o,
    output logic      [taxse_pkg::WORD_AW-1:0]  pm_addr_o,
    output logic                                pm_rd_o,
    input  wire logic [2*taxse_pkg::BYTE_W-1:0] pm_word_i,
    output logic      [taxse_pkg::FADDR_W-1:0]  fr_addr_o,
    output logic                                fr_rd_o,
    input  wire logic [taxse_pkg::BYTE_W-1:0]   fr_rdata_i,
    output logic                                fr_we_o,
    output logic      [taxse_pkg::BYTE_W-1:0]   fr_wdata_o,
    input  wire logic                           next_two_word_i,
    output logic                                skip_o,
    output logic                                busy_o
);
    import taxse_pkg::*;

    localparam int HIDX_W = $clog2(HOLD_N);
    localparam logic [7:0] HOLD_END = 8'(REG_HOLD + 4 * HOLD_N);

    taxse_state_t      state;
    taxse_state_t      next_state;
    taxse_op_t         op;
    logic [1:0]        phase;
    logic [OPC_W-1:0]  opcode;
    logic [BYTE_W-1:0] w_reg;
    logic              n_flag;
    logic              z_flag;
    logic              skipped;
    logic              illegal;
    logic              skip_take;
    logic              two_word;
    logic [1:0]        cyc_count;
    logic [1:0]        last_cycles;
    logic [PTR_W-1:0]  table_pointer;
    logic [BYTE_W-1:0] table_latch;
    logic [BYTE_W-1:0] latch_snap;
    logic [BANK_W-1:0] bank_select_reg;
    logic [BYTE_W-1:0] operand;
    logic [BYTE_W-1:0] xor_result;
    logic [BYTE_W-1:0] hold_rd;
    logic [HIDX_W-1:0] hold_rd_idx;
    logic              hold_we;
    logic              bus_req;
    logic              bus_wr;
    logic              issue;
    logic              last_q;
    logic [1:0]        mode;
    logic [7:0]        fsel;

    // merge written byte lanes onto the old value
    function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // bus qualifiers; a write lands at the edge where ack is seen
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr  = bus_req & wb_we_i & wb_ack_o;
    assign issue   = bus_wr & (wb_adr_i == REG_INSTR) & (state == st_idle);
    assign last_q  = (phase == PH_Q4);
    assign mode    = opcode[1:0];
    assign fsel    = opcode[7:0];
    assign busy_o  = (state != st_idle);

    // opcode decode
    always_comb begin
        if ((opcode & TBL_MASK) == TRD_PAT) begin
            op = op_trd; // [RL1]
        end else if ((opcode & TBL_MASK) == TWR_PAT) begin
            op = op_twr; // [RL5]
        end else if ((opcode & TST_MASK) == TST_PAT) begin
            op = op_tst; // [RL9]
        end else if ((opcode & XORL_MASK) == XORL_PAT) begin
            op = op_xorl; // [RL12]
        end else if ((opcode & XORF_MASK) == XORF_PAT) begin
            op = op_xorf; // [RL13]
        end else begin
            op = op_none;
        end
    end

    assign xor_result = w_reg ^ operand;

    // cycle sequencing: table ops and taken skips add cycles
    always_comb begin
        next_state = st_idle;
        case (state)
            st_cyc1: begin
                if (op == op_trd || op == op_twr) begin
                    next_state = st_cyc2; // [RL4] [RL7]
                end else if (op == op_tst && skip_take) begin
                    next_state = st_cyc2; // [RL10]
                end
            end
            st_cyc2: begin
                if (op == op_tst && two_word) begin
                    next_state = st_cyc3; // [RL10]
                end
            end
            default: next_state = st_idle;
        endcase
    end

    // state and phase counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= st_idle;
            phase <= PH_Q1;
        end else if (state == st_idle) begin
            if (issue) begin
                state <= st_cyc1;
                phase <= PH_Q1;
            end
        end else begin
            phase <= phase + 2'h1;
            if (last_q) begin
                state <= next_state;
            end
        end
    end

    // opcode register, issued from the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opcode <= OPC_RESET;
        end else if (issue) begin
            opcode <= OPC_W'(lanes({16'h0000, opcode}, wb_dat_i, wb_sel_i));
        end
    end

    // cycle count of the instruction in flight and of the last one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_count   <= 2'h0;
            last_cycles <= 2'h0;
        end else if (issue) begin
            cyc_count <= 2'h0;
        end else if (state != st_idle && last_q) begin
            cyc_count <= cyc_count + 2'h1;
            if (next_state == st_idle) begin
                last_cycles <= cyc_count + 2'h1;
            end
        end
    end

    // file register port: address, read strobe, operand capture, write back
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fr_addr_o  <= 12'h000;
            fr_rd_o    <= 1'b0;
            fr_we_o    <= 1'b0;
            fr_wdata_o <= BYTE_RESET;
            operand    <= BYTE_RESET;
        end else begin
            fr_rd_o <= 1'b0;
            fr_we_o <= 1'b0;
            if (state == st_cyc1 && phase == PH_Q1) begin
                if (opcode[ACC_BIT]) begin
                    fr_addr_o <= {bank_select_reg, fsel}; // [RL11]
                end else if (fsel < ACC_SPLIT) begin
                    fr_addr_o <= {ACC_LOW_BANK, fsel}; // [RL11]
                end else begin
                    fr_addr_o <= {ACC_HIGH_BANK, fsel}; // [RL11]
                end
                fr_rd_o <= (op == op_tst || op == op_xorf);
                operand <= fsel; // literal for the literal form
            end
            if (state == st_cyc1 && phase == PH_Q3) begin
                if (op == op_tst || op == op_xorf) begin
                    operand <= fr_rdata_i;
                end
                if (op == op_xorf && opcode[DEST_BIT]) begin
                    fr_we_o    <= 1'b1; // [RL14]
                    fr_wdata_o <= w_reg ^ fr_rdata_i; // [RL13]
                end
            end
        end
    end

    // skip decision, taken when the tested register reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            skip_take <= 1'b0;
            two_word  <= 1'b0;
            skip_o    <= 1'b0;
            skipped   <= 1'b0;
        end else begin
            if (issue) begin
                skip_take <= 1'b0;
                skipped   <= 1'b0;
            end else if (state == st_cyc1 && phase == PH_Q3) begin
                skip_take <= (op == op_tst) && (fr_rdata_i == BYTE_RESET); // [RL9]
            end
            if (state == st_cyc1 && last_q) begin
                two_word <= next_two_word_i;
                skip_o   <= skip_take; // [RL9]
                skipped  <= skip_take;
            end else if (last_q && next_state == st_idle) begin
                skip_o <= 1'b0;
            end
        end
    end

    // working register and flags; only the exclusive-or forms touch flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_reg  <= BYTE_RESET;
            n_flag <= 1'b0;
            z_flag <= 1'b0;
        end else if (state == st_cyc1 && last_q && (op == op_xorl || op == op_xorf)) begin
            n_flag <= xor_result[BYTE_W-1]; // [RL12] [RL13]
            z_flag <= (xor_result == BYTE_RESET);
            if (op == op_xorl || !opcode[DEST_BIT]) begin
                w_reg <= xor_result; // [RL12] [RL14]
            end
        end else if (state == st_idle && bus_wr && wb_adr_i == REG_WORK) begin
            w_reg <= BYTE_W'(lanes({24'h00_0000, w_reg}, wb_dat_i, wb_sel_i));
        end
    end

    // bank select register, software owned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_select_reg <= 4'h0;
        end else if (state == st_idle && bus_wr && wb_adr_i == REG_BANK && wb_sel_i[0]) begin
            bank_select_reg <= wb_dat_i[BANK_W-1:0];
        end
    end

    // table pointer: pre-increment ends cycle one, post steps end cycle two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            table_pointer <= PTR_RESET;
        end else if ((op == op_trd || op == op_twr) && last_q) begin
            if (state == st_cyc1 && mode == MODE_PREINC) begin
                table_pointer <= table_pointer + PTR_STEP; // [RL1] [RL5] [RL15]
            end else if (state == st_cyc2 && mode == MODE_POSTINC) begin
                table_pointer <= table_pointer + PTR_STEP; // [RL1] [RL15]
            end else if (state == st_cyc2 && mode == MODE_POSTDEC) begin
                table_pointer <= table_pointer - PTR_STEP; // [RL1] [RL15]
            end
        end else if (state == st_idle && bus_wr && wb_adr_i == REG_TPTR) begin
            table_pointer <= PTR_W'(lanes({11'h000, table_pointer}, wb_dat_i,
                                          wb_sel_i)); // [RL2]
        end
    end

    // program memory read: word address and strobe both set in Q1 of cycle two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pm_addr_o <= 20'h0_0000;
            pm_rd_o   <= 1'b0;
        end else begin
            pm_rd_o <= 1'b0;
            if (state == st_cyc2 && phase == PH_Q1 && op == op_trd) begin
                pm_addr_o <= table_pointer[PTR_W-1:1]; // [RL2]
                pm_rd_o   <= 1'b1; // [RL4]
            end
        end
    end

    // table latch: memory byte at end of cycle two, snapshot for table write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            table_latch <= BYTE_RESET;
            latch_snap  <= BYTE_RESET;
        end else if (state == st_cyc2 && op == op_trd && last_q) begin
            if (table_pointer[0]) begin
                table_latch <= pm_word_i[2*BYTE_W-1:BYTE_W]; // [RL3] [RL4]
            end else begin
                table_latch <= pm_word_i[BYTE_W-1:0]; // [RL3] [RL4]
            end
        end else if (state == st_cyc2 && op == op_twr && phase == PH_Q2) begin
            latch_snap <= table_latch; // [RL7]
        end else if (state == st_idle && bus_wr && wb_adr_i == REG_TLAT && wb_sel_i[0]) begin
            table_latch <= wb_dat_i[BYTE_W-1:0];
        end
    end

    // holding registers take the snapshot at the last phase; no path to program memory
    assign hold_we     = (state == st_cyc2) && (op == op_twr) && last_q; // [RL7] [RL8]
    assign hold_rd_idx = wb_adr_i[2 +: HIDX_W];

    taxse_hold_bank #(
        .DEPTH (HOLD_N),
        .IDX_W (HIDX_W)
    ) u_hold (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .we_i      (hold_we),
        .wr_idx_i  (table_pointer[HIDX_W-1:0]), // [RL6]
        .wr_data_i (latch_snap),
        .rd_idx_i  (hold_rd_idx),
        .rd_data_o (hold_rd)
    );

    // illegal opcode flag, refreshed by every issue
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            illegal <= 1'b0;
        end else if (state == st_cyc1 && phase == PH_Q1) begin
            illegal <= (op == op_none);
        end
    end

    // bus slave: one wait state, reads registered, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= WORD_ZERO;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= WORD_ZERO;
            if (bus_req && !wb_ack_o) begin
                if (wb_adr_i == REG_INSTR) begin
                    wb_dat_o[OPC_W-1:0] <= opcode;
                end else if (wb_adr_i == REG_STATUS) begin
                    wb_dat_o[ST_BUSY]               <= busy_o;
                    wb_dat_o[ST_NEG]                <= n_flag;
                    wb_dat_o[ST_ZERO]               <= z_flag;
                    wb_dat_o[ST_SKIP]               <= skipped;
                    wb_dat_o[ST_ILLEGAL]            <= illegal;
                    wb_dat_o[ST_CYC_LSB +: 2]       <= last_cycles;
                end else if (wb_adr_i == REG_WORK) begin
                    wb_dat_o[BYTE_W-1:0] <= w_reg;
                end else if (wb_adr_i == REG_TPTR) begin
                    wb_dat_o[PTR_W-1:0] <= table_pointer;
                end else if (wb_adr_i == REG_TLAT) begin
                    wb_dat_o[BYTE_W-1:0] <= table_latch;
                end else if (wb_adr_i == REG_BANK) begin
                    wb_dat_o[BANK_W-1:0] <= bank_select_reg;
                end else if (wb_adr_i >= REG_HOLD && wb_adr_i < HOLD_END) begin
                    wb_dat_o[BYTE_W-1:0] <= hold_rd;
                end
            end
        end
    end

endmodule

// ### test/taxse_core_properties.sv
// concurrent checks on the execution core ports
`timescale 1ns/10ps
module taxse_core_properties (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic [19:0] pm_addr_o,
    input  wire logic        pm_rd_o,
    input  wire logic        fr_rd_o,
    input  wire logic        fr_we_o,
    input  wire logic        skip_o,
    input  wire logic        busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // shortest instruction keeps busy for one full instruction cycle
    sequence busy_run;
        busy_o [*4];
    endsequence
    sequence req_seen;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // bus answer and data idle level
    bus_answer_a: assert property (req_seen |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus request not answered by a single ack");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    // instruction length is one, two or three cycles of four phases
    instr_len_a: assert property ($rose(busy_o) |-> busy_run ##[1:9] !busy_o)
        else $error("busy length out of range");
    // program memory read happens only in cycle two, one strobe, stable address
    pm_late_a: assert property ($rose(busy_o) |-> !pm_rd_o [*5])
        else $error("program read before cycle two");
    pm_pulse_a: assert property (pm_rd_o |-> busy_o ##1 (!pm_rd_o && $stable(pm_addr_o)))
        else $error("program read strobe malformed");
    // file register access
    file_read_a: assert property (fr_rd_o |-> busy_o ##1 !fr_rd_o)
        else $error("file read strobe malformed");
    file_write_a: assert property (fr_we_o |-> busy_o && $past(fr_rd_o, 2) ##1 !fr_we_o)
        else $error("file write without preceding read");
    skip_busy_a: assert property (skip_o |-> busy_o)
        else $error("skip flag outside execution");
endmodule

// ### test/taxse_mem_model.sv
// program memory and file register model facing the core
`timescale 1ns/10ps
module taxse_mem_model (
    input  wire logic        clk_i,
    input  wire logic [19:0] pm_addr_i,
    input  wire logic        pm_rd_i,
    output logic      [15:0] pm_word_o,
    input  wire logic [11:0] fr_addr_i,
    input  wire logic        fr_rd_i,
    input  wire logic        fr_we_i,
    input  wire logic [7:0]  fr_wdata_i,
    output logic      [7:0]  fr_rdata_o
);
    logic [7:0]  mem [0:4095];
    logic [1:0]  pm_win = 2'h0;
    logic [15:0] pm_word = 16'h0000;
    logic        fr_win = 1'b0;
    // word valid for three clocks after the strobe, scrambled otherwise so stale use shows
    always @(posedge clk_i) begin
        pm_win <= pm_rd_i ? 2'h2 : (pm_win != 2'h0 ? pm_win - 2'h1 : 2'h0);
        if (pm_rd_i)
            pm_word <= pm_addr_i[15:0] ^ 16'ha55a;
        else if (pm_win == 2'h0)
            pm_word <= ~pm_word;
        fr_win <= fr_rd_i;
        if (fr_we_i)
            mem[fr_addr_i] <= fr_wdata_i;
    end
    assign pm_word_o  = pm_word;
    assign fr_rdata_o = (fr_rd_i || fr_win) ? mem[fr_addr_i] : ~mem[fr_addr_i];
endmodule

// ### test/testbench.sv
// self-checking bench for the execution core
`timescale 1ns/10ps
module testbench;
    import taxse_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd, st;
    logic        wb_ack_o, pm_rd_o, fr_rd_o, fr_we_o, skip_o, busy_o, next_two_word_i = 1'b0;
    logic [19:0] pm_addr_o;
    logic [15:0] pm_word_i, op;
    logic [11:0] fr_addr_o, fa;
    logic [7:0]  fr_rdata_i, fr_wdata_o, v, w, k, r, xw, f;
    logic [20:0] p, a, fin;
    logic [3:0]  b;
    logic [1:0]  m, fl;
    integer      seed = 32'h84d0, error_cnt = 0, n_compared = 0, cycles = 0, skip_n = 0;
    taxse_core #(.HOLD_N(8)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pm_addr_o, .pm_rd_o, .pm_word_i, .fr_addr_o,
        .fr_rd_o, .fr_rdata_i, .fr_we_o, .fr_wdata_o, .next_two_word_i, .skip_o, .busy_o);
    taxse_mem_model P (.clk_i, .pm_addr_i(pm_addr_o), .pm_rd_i(pm_rd_o), .pm_word_o(pm_word_i),
        .fr_addr_i(fr_addr_o), .fr_rd_i(fr_rd_o), .fr_we_i(fr_we_o), .fr_wdata_i(fr_wdata_o),
        .fr_rdata_o(fr_rdata_i));
    // clock, hang guard and count of discarded cycles
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (skip_o)
            skip_n <= skip_n + 1;
        if (cycles == 40000) begin
            error_cnt = error_cnt + 1;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle: hold until ack is sampled, then release
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= wr;
        wb_adr_i <= ad;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // issue an opcode, poll until idle, check the cycle count
    task automatic run(input logic [15:0] o, input logic [1:0] ncyc);
        bus(1'b1, REG_INSTR, {16'h0000, o});
        do begin
            bus(1'b0, REG_STATUS, 32'h0000_0000);
        end while (rd[ST_BUSY] !== 1'b0);
        st = rd;
        chk(rd[9:8], ncyc);
    endtask
    function automatic logic [7:0] pm_byte(input logic [20:0] q);
        logic [15:0] wd;
        wd = q[16:1] ^ 16'ha55a;
        return q[0] ? wd[15:8] : wd[7:0];
    endfunction
    function automatic logic [11:0] faddr(input logic acc, input logic [7:0] fo);
        return acc ? {b, fo} : {fo[7] ? ACC_HIGH_BANK : ACC_LOW_BANK, fo};
    endfunction
    // main sequence: reset state, xor, test-skip, table access
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b0, 8'h80, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, REG_HOLD + 8'(4 * i), 32'h0000_0000);
            chk(rd, {24'h00_0000, HOLD_RESET});
        end
        run(16'hffff, 2'h1);
        chk(st[ST_ILLEGAL], 1'b1);
        for (int i = 0; i < 24; i++) begin
            w = 8'($random(seed));
            k = (i % 5 == 0) ? w : 8'($random(seed));
            b = 4'($random(seed));
            op = 16'($random(seed));
            if (i < 12)
                op[8:0] = {1'b0, i[0], {7{~i[0]}}};
            bus(1'b1, REG_WORK, {24'h00_0000, w});
            bus(1'b1, REG_BANK, {28'h000_0000, b});
            r = w ^ k;
            xw = r;
            if (i < 8) begin
                run(XORL_PAT | {8'h00, k}, 2'h1);
            end else begin
                fa = faddr(op[ACC_BIT], op[7:0]);
                P.mem[fa] = k;
                run(XORF_PAT | {6'h00, op[9:0]}, 2'h1);
                xw = op[DEST_BIT] ? w : r;
                chk(P.mem[fa], op[DEST_BIT] ? r : k);
            end
            bus(1'b0, REG_WORK, 32'h0000_0000);
            chk(rd, xw);
            chk({st[ST_ZERO], st[ST_NEG]}, {r == 8'h00, r[7]});
        end
        for (int i = 0; i < 8; i++) begin
            f = 8'($random(seed));
            b = 4'($random(seed));
            k = i[1] ? 8'h00 : 8'($random(seed)) | 8'h01;
            fa = faddr(i[0], f);
            P.mem[fa] = k;
            bus(1'b1, REG_BANK, {28'h000_0000, b});
            next_two_word_i <= i[2];
            skip_n = 0;
            run(TST_PAT | {7'h00, i[0], f}, i[1] ? 2'h2 + {1'b0, i[2]} : 2'h1);
            chk({st[ST_ILLEGAL], st[ST_SKIP]}, {1'b0, i[1]});
            chk(skip_n, i[1] ? 4 << i[2] : 0);
            chk(P.mem[fa], k);
        end
        fl = st[2:1];
        for (int i = 0; i < 16; i++) begin
            p = (i < 8) ? {21{i[0]}} : 21'($random(seed));
            m = i[1:0];
            a = (m == MODE_PREINC) ? p + PTR_STEP : p;
            fin = (m == MODE_POSTDEC) ? p - PTR_STEP : (m == MODE_KEEP) ? p : p + PTR_STEP;
            v = 8'($random(seed));
            bus(1'b1, REG_TPTR, {11'h000, p});
            bus(1'b1, REG_TLAT, {24'h00_0000, v});
            run((i[2] ? TWR_PAT : TRD_PAT) | {14'h0000, m}, 2'h2);
            chk(st[2:1], fl);
            bus(1'b0, REG_TLAT, 32'h0000_0000);
            chk(rd, i[2] ? v : pm_byte(a));
            bus(1'b0, REG_TPTR, 32'h0000_0000);
            chk(rd, fin);
            if (i[2]) begin
                bus(1'b0, REG_HOLD + {3'h0, a[2:0], 2'h0}, 32'h0000_0000);
                chk(rd, v);
            end
        end
        stop_test();
    end
endmodule
bind taxse_core taxse_core_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .pm_addr_o, .pm_rd_o, .fr_rd_o, .fr_we_o, .skip_o, .busy_o);
